// ==== core/mbp_port.sv ====
// multiplexed 8-bit host bus port with interrupt mask and clear logic
`include "mbp_regs.svh"
module mbp_port #(
	parameter int NSRC = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// host bus controls
	input wire logic ale,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic bus_style_select,
	// shared address data lines
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic ad_oe,
	// interrupt sources and request
	input wire logic [NSRC-1:0] irq_events,
	output logic irq_request_n,
	output logic irq_request_oe
);
	logic ale_s1, ale_s2, ale_s3;
	logic cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2;
	logic [7:0] ad_s1, ad_s2;
	logic cs_q, rd_q, wr_q;
	logic [7:0] addr_r;
	logic [7:0] wdata_r;
	logic rd_act, wr_act, rise_any, wr_commit;
	logic [1:0] kind_w;
	logic [7:0] irq_mask_bits, irq_pend_r;
	logic [7:0] mem_rdata;
	logic mem_we;
	mbp_pkg::mbp_state_t state_r;

	// decodes whether the strobes form an enabled read or write
	function automatic logic [1:0] cycle_kind(input logic sel,
		input logic cs, input logic rd, input logic wr);
		logic [1:0] k;
		k = 2'b00;
		if (!cs) begin
			if (!sel) begin
				k = {!wr, !rd};
			end else if (!rd) begin
				k = wr ? 2'b01 : 2'b10;
			end
		end
		return k;
	endfunction

	// two-stage synchronisers; first stage feeds only the second
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ale_s1 <= 1'b0;
			ale_s2 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			rd_s1 <= 1'b1;
			rd_s2 <= 1'b1;
			wr_s1 <= 1'b1;
			wr_s2 <= 1'b1;
			ad_s1 <= 8'h00;
			ad_s2 <= 8'h00;
		end else begin
			ale_s1 <= ale;
			ale_s2 <= ale_s1;
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			rd_s1 <= rd_n;
			rd_s2 <= rd_s1;
			wr_s1 <= wr_n;
			wr_s2 <= wr_s1;
			ad_s1 <= ad_in;
			ad_s2 <= ad_s1;
		end
	end

	// delayed copies for edge detection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ale_s3 <= 1'b0;
			cs_q <= 1'b1;
			rd_q <= 1'b1;
			wr_q <= 1'b1;
		end else begin
			ale_s3 <= ale_s2;
			cs_q <= cs_s2;
			rd_q <= rd_s2;
			wr_q <= wr_s2;
		end
	end

	// address latched on falling edge of ale, held for data phase
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_r <= 8'h00;
		end else if (ale_s3 && !ale_s2) begin
			addr_r <= ad_s2;
		end
	end

	// access decode; style select chooses strobe meaning
	always_comb begin
		kind_w = cycle_kind(bus_style_select, cs_s2, rd_s2, wr_s2);
		rd_act = kind_w[0];
		wr_act = kind_w[1];
	end

	// write data sampled while the write is active; stored when it ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wdata_r <= 8'h00;
		end else if (wr_act) begin
			wdata_r <= ad_s2;
		end
	end

	// first rising edge of any qualifying signal ends the write
	// a rising edge on any qualifying strobe in this cycle
	assign rise_any = (cs_s2 && !cs_q) || (wr_s2 && !wr_q) ||
		(rd_s2 && !rd_q && bus_style_select);
	assign wr_commit = (state_r == mbp_pkg::MBP_WRITE) && rise_any;
	assign mem_we = wr_commit;

	// access state tracking
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= mbp_pkg::MBP_IDLE;
		end else begin
			case (state_r)
				mbp_pkg::MBP_IDLE: begin
					if (rd_act) begin
						state_r <= mbp_pkg::MBP_READ;
					end else if (wr_act) begin
						state_r <= mbp_pkg::MBP_WRITE;
					end
				end
				mbp_pkg::MBP_READ: begin
					if (!rd_act) begin
						state_r <= mbp_pkg::MBP_IDLE;
					end
				end
				mbp_pkg::MBP_WRITE: begin
					if (!wr_act) begin
						state_r <= mbp_pkg::MBP_IDLE;
					end
				end
				default: begin
					state_r <= mbp_pkg::MBP_IDLE;
				end
			endcase
		end
	end

	// backing store for all 256 locations
	mbp_mem #(
		.AW(`MBP_ADDR_W),
		.DW(`MBP_DATA_W)
	) u_mem (
		.clk(clk),
		.wr_en(mem_we),
		.wr_addr(addr_r),
		.wr_data(wdata_r),
		.rd_addr(addr_r),
		.rd_data(mem_rdata)
	);

	// interrupt mask register, preset at reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_mask_bits <= `MBP_IRQ_MASK_RST;
		end else if (wr_commit && addr_r == `MBP_IRQ_MASK_ADDR) begin
			irq_mask_bits <= wdata_r;
		end
	end

	// pending flags: events win over a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_pend_r <= 8'h00;
		end else if (wr_commit && addr_r == `MBP_IRQ_CLEAR_ADDR) begin
			irq_pend_r <= (irq_pend_r & wdata_r) | irq_events;
		end else begin
			irq_pend_r <= irq_pend_r | irq_events;
		end
	end

	// read data: pending and mask registers mapped, rest (clear address included) from store
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ad_out <= 8'h00;
		end else if (addr_r == `MBP_IRQ_PEND_ADDR) begin
			ad_out <= irq_pend_r;
		end else if (addr_r == `MBP_IRQ_MASK_ADDR) begin
			ad_out <= irq_mask_bits;
		end else begin
			ad_out <= mem_rdata;
		end
	end

	// bus driven only during an enabled read; no wait output exists
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ad_oe <= 1'b0;
		end else begin
			ad_oe <= rd_act;
		end
	end

	// open-drain request: pull low while an unmasked flag is pending
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_request_n <= 1'b0;
			irq_request_oe <= 1'b0;
		end else begin
			irq_request_n <= 1'b0;
			irq_request_oe <= |(irq_pend_r & ~irq_mask_bits);
		end
	end
endmodule

// ==== core/mbp_regs.svh ====
// constants, register offsets and reset values of the bus port
`ifndef MBP_REGS_SVH
`define MBP_REGS_SVH
`define MBP_ADDR_W 8
`define MBP_DATA_W 8
`define MBP_IRQ_MASK_ADDR 8'heb
`define MBP_IRQ_CLEAR_ADDR 8'hec
`define MBP_IRQ_PEND_ADDR 8'h1f
`define MBP_IRQ_MASK_RST 8'hff
`define MBP_IRQ_CLEAR_RST 8'hff
`define MBP_SYNC_STAGES 2
`endif

// ==== core/mbp_pkg.sv ====
// types shared by the bus port files
package mbp_pkg;
	typedef enum logic [1:0] {
		MBP_IDLE = 2'b00,
		MBP_READ = 2'b01,
		MBP_WRITE = 2'b10
	} mbp_state_t;
endpackage

// ==== core/mbp_mem.sv ====
// 256 by 8 register store with registered read data
module mbp_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// write store
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

// ==== bench/mbp_port_chk_sva.sv ====
// pin level assertions for the host bus port
module mbp_port_chk #(parameter int NSRC = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus
	input wire logic ale,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic bus_style_select,
	input wire logic [7:0] ad_in,
	input wire logic [7:0] ad_out,
	input wire logic ad_oe,
	// interrupt
	input wire logic [NSRC-1:0] irq_events,
	input wire logic irq_request_n,
	input wire logic irq_request_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic rd_c, w0, w1;
	logic [7:0] act_r;
	// read and write conditions at the pins
	assign rd_c = !cs_n && !rd_n && (!bus_style_select || wr_n);
	assign w0 = !cs_n && !wr_n && rd_n && !bus_style_select;
	assign w1 = !cs_n && !wr_n && !rd_n && bus_style_select;
	// history of events and writes that may move the request
	always_ff @(posedge clk or posedge reset)
		if (reset) act_r <= 8'h00;
		else act_r <= {act_r[6:0], (|irq_events) | w0 | w1};
	property p_cs; cs_n[*4] |-> !ad_oe; endproperty
	a_cs: assert property (p_cs) else $error("bus driven unselected");
	property p_rd0; (!bus_style_select && rd_c)[*4] |-> ad_oe; endproperty
	a_rd0: assert property (p_rd0) else $error("no read drive");
	property p_w0; w0[*4] |-> !ad_oe; endproperty
	a_w0: assert property (p_w0) else $error("drive in write");
	property p_rd1; (bus_style_select && rd_c)[*4] |-> ad_oe; endproperty
	a_rd1: assert property (p_rd1) else $error("no strobe read");
	property p_w1; w1[*4] |-> !ad_oe; endproperty
	a_w1: assert property (p_w1) else $error("drive in strobe write");
	property p_lat; $rose(ad_oe) |-> $past(rd_c, 3); endproperty
	a_lat: assert property (p_lat) else $error("drive latency");
	property p_rel; $fell(ad_oe) |-> !$past(rd_c, 3); endproperty
	a_rel: assert property (p_rel) else $error("early release");
	property p_irq; $changed(irq_request_oe) |-> |act_r; endproperty
	a_irq: assert property (p_irq) else $error("request moved alone");
	c_rd: cover property ($rose(ad_oe));
	c_w1: cover property (w1[*4]);
	c_irq: cover property ($fell(irq_request_oe));
endmodule
bind mbp_port mbp_port_chk #(.NSRC(NSRC)) mbp_port_chk_i (
	.clk(clk),
	.reset(reset),
	.ale(ale),
	.cs_n(cs_n),
	.rd_n(rd_n),
	.wr_n(wr_n),
	.bus_style_select(bus_style_select),
	.ad_in(ad_in),
	.ad_out(ad_out),
	.ad_oe(ad_oe),
	.irq_events(irq_events),
	.irq_request_n(irq_request_n),
	.irq_request_oe(irq_request_oe)
);

// ==== bench/mbp_host.sv ====
// host processor model on the multiplexed bus
module mbp_host (
	// clock
	input wire logic clk,
	// bus
	output logic ale,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic bus_style_select,
	output logic [7:0] ad_in,
	input wire logic [7:0] ad_out,
	input wire logic ad_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hd_oe = 0;
	logic [7:0] hd = 8'h00, idle_r = 8'h3c;
	initial {ale, cs_n, rd_n, wr_n, bus_style_select} = 5'h0e;
	// wire level; an undriven bus wanders every cycle
	assign ad_in = ad_oe ? ad_out : hd_oe ? hd : idle_r;
	always @(posedge clk) idle_r <= idle_r + 8'h35;
	// one access: address phase, then strobes held five cycles
	task automatic acc(input logic sty, w, en, input logic [7:0] a, d);
		@(negedge clk);
		{bus_style_select, ale, hd_oe, hd} = {sty, 2'b11, a};
		@(negedge clk);
		ale = 0;
		repeat (3) @(negedge clk);
		hd_oe = w;
		hd = d;
		cs_n = !en;
		rd_n = w && !sty;
		wr_n = !w;
		repeat (5) @(negedge clk);
		{cs_n, rd_n, wr_n} = 3'b111;
		repeat (5) @(negedge clk);
		hd_oe = 0;
	endtask
endmodule

// ==== bench/mbp_port_tb.sv ====
// self-checking bench for the host bus port
module mbp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, ale, cs_n, rd_n, wr_n, bss, ad_oe, irq_n, irq_oe;
	logic [7:0] ad_in, ad_out, irq_events = 8'h00, lf = 8'h1c;
	logic [7:0] exp_q [$];
	logic oe_q = 0;
	int errors = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	mbp_port mbp_port_i (.clk(clk), .reset(reset), .ale(ale), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .bus_style_select(bss), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe(ad_oe), .irq_events(irq_events),
		.irq_request_n(irq_n), .irq_request_oe(irq_oe));
	mbp_host mbp_host_i (.clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .bus_style_select(bss), .ad_in(ad_in), .ad_out(ad_out),
		.ad_oe(ad_oe));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, s);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rd(input logic sty, input logic [7:0] a, e);
		exp_q.push_back(e);
		mbp_host_i.acc(sty, 0, 1, a, 8'h00);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watcher: each new read drive takes the oldest note
	always @(negedge clk) begin
		oe_q <= ad_oe;
		if (ad_oe && !oe_q && exp_q.size() == 0) chk("drive", 8'h00, 8'hff);
		else if (ad_oe && !oe_q) chk("read", exp_q.pop_front(), ad_out);
	end
	initial begin
		#20000;
		errors++;
		wrap_up();
	end
	initial begin
		logic [7:0] a, d;
		repeat (3) @(negedge clk);
		reset = 0;
		chk("idle", 8'h00, {6'h00, ad_oe, irq_oe});
		$display("reset test done");
		// write then read back at once, styles crossed, edges first
		for (int i = 0; i < 16; i++) begin
			lf = nx(lf);
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lf;
			if (a == 8'heb || a == 8'hec || a == 8'h1f) a = a ^ 8'h40;
			lf = nx(lf);
			d = lf;
			mbp_host_i.acc(i[0], 1, 1, a, d);
			rd(!i[0], a, d);
		end
		$display("data test done");
		// unselected write and read leave store and bus alone
		mbp_host_i.acc(0, 1, 0, a, ~d);
		mbp_host_i.acc(1, 0, 0, a, 8'h00);
		rd(1, a, d);
		$display("select test done");
		// source 0 unmasked, source 1 masked
		mbp_host_i.acc(0, 1, 1, 8'heb, 8'hfe);
		@(negedge clk) irq_events = 8'h03;
		@(negedge clk) irq_events = 8'h00;
		repeat (4) @(negedge clk);
		chk("irq set", 8'h01, {7'h00, irq_oe});
		chk("irq pin", 8'h00, {7'h00, irq_n});
		rd(0, 8'h1f, 8'h03);
		mbp_host_i.acc(1, 1, 1, 8'hec, 8'hfe);
		repeat (4) @(negedge clk);
		chk("irq clear", 8'h00, {7'h00, irq_oe});
		$display("irq test done");
		wrap_up();
	end
endmodule
